/* core/asio_pkg.sv */
`default_nettype none
// ==================================================
// Shared constants and carriers
package asio_pkg;
  // Frame and field sizes
  localparam int WORD_LEN = 13;
  localparam int SEL_W = 4;
  localparam int MODE_W = 4;
  localparam int CFG_W = SEL_W + MODE_W;
  localparam int IDX_W = 4;
  // Timing counts, in conversion clock rising edges
  localparam int ACQ_CCLKS = 10;
  localparam int CONFIG_WRITE_N_CCLKS = 44;
  localparam int CC_CNT_W = 8;
  // Reset values
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic [WORD_LEN-1:0] RESULT_RST = 13'h0000;

  // Channel and mode as shifted in, channel first
  typedef struct packed {
    logic [SEL_W-1:0] input_selector;
    logic [MODE_W-1:0] mode;
  } asio_cfg_t;

  typedef enum logic [1:0] {
    CV_IDLE,
    CV_ACQ,
    CV_CONFIG_WRITE_N
  } asio_config_write_n_state_t;
endpackage : asio_pkg
`default_nettype wire

/* core/asio_port.sv */
`default_nettype none
// Notes on behaviour
// - Shift-done flag low while result shifts out, high once all bits left.
// - Host shift clock paces every input bit and every result bit after the first.
// - First eight shift clock rising edges of a frame capture serial_in into channel and mode register.
// - Captured word selects input channel and converter mode.
// - While selected, each shift clock falling edge presents next result bit.
// - Select held low: first result bit appears when end-of-conversion rises.
// - Select toggled: first result bit appears on select falling edge.
// - Acquisition and conversion intervals count the conversion clock only.
// - End-of-conversion low while busy, rises when the cycle ends.
// - Thirteen shift clocks per transfer; host keeps that count with select low.
// - Config-write input high: read only, input ignored, no conversion started.
// - Select falling during conversion aborts it; result keeps the last completed word.
module asio_port (
  // System clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Serial link from the host
  input wire logic SCLK_IN,
  input wire logic CS_N,
  input wire logic SERIAL_IN,
  input wire logic CONFIG_WRITE_N,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE_N,
  output logic SHIFT_DONE_FLAG,
  // Converter side
  input wire logic CONVERSION_CLOCK,
  input wire logic [asio_pkg::WORD_LEN-1:0] SAMPLE_IN,
  output logic END_OF_CONFIG_WRITE_N,
  output asio_pkg::asio_cfg_t CONFIG
);
  // ==================================================
  // Link domain, clocked by the host shift clock
  logic link_clr_n;
  logic [asio_pkg::IDX_W-1:0] rise_cnt_reg;
  logic [asio_pkg::CFG_W-1:0] cfg_shift_reg;
  logic [asio_pkg::CFG_W-1:0] cfg_hold_reg;
  logic word_tgl_reg;
  logic fall_tgl_reg;
  logic frame_end;

  // Deselect clears the bit count, so a toggled select always restarts the frame
  assign link_clr_n = RESET_N & ~CS_N;
  assign frame_end = (rise_cnt_reg == asio_pkg::IDX_W'(asio_pkg::WORD_LEN - 1));

  // Rising edge count, wraps after a full word for continuous select
  always_ff @(posedge SCLK_IN or negedge link_clr_n) begin
    if (!link_clr_n) begin
      rise_cnt_reg <= '0;
    end else if (frame_end) begin
      rise_cnt_reg <= '0;
    end else begin
      rise_cnt_reg <= rise_cnt_reg + 1'b1;
    end
  end

  // Channel and mode bits lead the frame; later bits are don't-care
  always_ff @(posedge SCLK_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_shift_reg <= '0;
    end else if (rise_cnt_reg < asio_pkg::IDX_W'(asio_pkg::CFG_W)) begin
      cfg_shift_reg <= {cfg_shift_reg[asio_pkg::CFG_W-2:0], SERIAL_IN};
    end
  end

  // Word handed over with a toggle; hold stays still for a whole frame
  always_ff @(posedge SCLK_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_hold_reg <= '0;
      word_tgl_reg <= 1'b0;
    end else if (frame_end) begin
      cfg_hold_reg <= cfg_shift_reg;
      word_tgl_reg <= ~word_tgl_reg;
    end
  end

  // One toggle per falling edge drives the output bit index
  always_ff @(negedge SCLK_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      fall_tgl_reg <= 1'b0;
    end else begin
      fall_tgl_reg <= ~fall_tgl_reg;
    end
  end

  // ==================================================
  // Crossings into the system clock
  logic cs_s1, cs_s2, cs_d;
  logic cc_s1, cc_s2, cc_d;
  logic ft_s1, ft_s2, ft_d;
  logic wt_s1, wt_s2, wt_d;
  logic cw_s1, cw_s2;

  // Two-stage synchronisers, then a delay stage for edges
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {cc_s1, cc_s2, cc_d} <= 3'h0;
      {ft_s1, ft_s2, ft_d} <= 3'h0;
      {wt_s1, wt_s2, wt_d} <= 3'h0;
      {cw_s1, cw_s2} <= 2'h3;
    end else begin
      {cs_s1, cs_s2, cs_d} <= {CS_N, cs_s1, cs_s2};
      {cc_s1, cc_s2, cc_d} <= {CONVERSION_CLOCK, cc_s1, cc_s2};
      {ft_s1, ft_s2, ft_d} <= {fall_tgl_reg, ft_s1, ft_s2};
      {wt_s1, wt_s2, wt_d} <= {word_tgl_reg, wt_s1, wt_s2};
      {cw_s1, cw_s2} <= {CONFIG_WRITE_N, cw_s1};
    end
  end

  logic cs_fall, cc_rise, fall_ev, word_ev;
  assign cs_fall = cs_d & ~cs_s2;
  assign cc_rise = cc_s2 & ~cc_d;
  assign fall_ev = ft_s2 ^ ft_d;
  assign word_ev = wt_s2 ^ wt_d;

  // ==================================================
  // Conversion sequencer
  asio_pkg::asio_config_write_n_state_t state_reg, state_next;
  logic [asio_pkg::CC_CNT_W-1:0] cc_cnt_reg, cc_cnt_next;
  logic [asio_pkg::WORD_LEN-1:0] sample_reg, result_reg, result_next;
  logic start_config_write_n;

  // Read-only frames neither reprogram nor start anything
  assign start_config_write_n = word_ev & ~cw_s2;

  always_comb begin
    state_next = state_reg;
    cc_cnt_next = cc_cnt_reg;
    result_next = result_reg;
    unique case (state_reg)
      asio_pkg::CV_IDLE: begin
        if (start_config_write_n) begin
          state_next = asio_pkg::CV_ACQ;
          cc_cnt_next = '0;
        end
      end
      asio_pkg::CV_ACQ: begin
        if (cc_rise) begin
          if (cc_cnt_reg == asio_pkg::CC_CNT_W'(asio_pkg::ACQ_CCLKS - 1)) begin
            state_next = asio_pkg::CV_CONFIG_WRITE_N;
            cc_cnt_next = '0;
          end else begin
            cc_cnt_next = cc_cnt_reg + 1'b1;
          end
        end
      end
      asio_pkg::CV_CONFIG_WRITE_N: begin
        if (cc_rise) begin
          if (cc_cnt_reg == asio_pkg::CC_CNT_W'(asio_pkg::CONFIG_WRITE_N_CCLKS - 1)) begin
            state_next = asio_pkg::CV_IDLE;
            result_next = sample_reg;
          end else begin
            cc_cnt_next = cc_cnt_reg + 1'b1;
          end
        end
      end
    endcase
    // Abort wins; the new sequence waits for the next full frame
    if (cs_fall && state_reg != asio_pkg::CV_IDLE) begin
      state_next = asio_pkg::CV_IDLE;
    end
  end

  // Sequencer state, sample taken as acquisition closes
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= asio_pkg::CV_IDLE;
      cc_cnt_reg <= '0;
      sample_reg <= asio_pkg::RESULT_RST;
      result_reg <= asio_pkg::RESULT_RST;
    end else begin
      state_reg <= state_next;
      cc_cnt_reg <= cc_cnt_next;
      result_reg <= result_next;
      if (state_reg == asio_pkg::CV_ACQ && state_next == asio_pkg::CV_CONFIG_WRITE_N) begin
        sample_reg <= SAMPLE_IN;
      end
    end
  end

  // Busy flag, low through acquisition and conversion
  logic eoc_next, eoc_rise;
  assign eoc_next = (state_next == asio_pkg::CV_IDLE);
  assign eoc_rise = eoc_next & ~END_OF_CONFIG_WRITE_N;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      END_OF_CONFIG_WRITE_N <= 1'b1;
    end else begin
      END_OF_CONFIG_WRITE_N <= eoc_next;
    end
  end

  // Channel and mode take effect only on configuration frames
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONFIG <= '{input_selector: asio_pkg::SEL_RST, mode: asio_pkg::MODE_RST};
    end else if (start_config_write_n) begin
      CONFIG <= asio_pkg::asio_cfg_t'(cfg_hold_reg);
    end
  end

  // ==================================================
  // Result shifter
  logic [asio_pkg::IDX_W-1:0] idx_reg, idx_next;
  localparam logic [asio_pkg::IDX_W-1:0] IDX_DONE = asio_pkg::IDX_W'(asio_pkg::WORD_LEN);

  always_comb begin
    idx_next = idx_reg;
    if (cs_fall) begin
      idx_next = '0;
    end else if (eoc_rise && !cs_s2) begin
      idx_next = '0;
    end else if (fall_ev && !cs_s2 && idx_reg != IDX_DONE) begin
      idx_next = idx_reg + 1'b1;
    end
  end

  // Output bits are one sync delay behind the clock edge; fine at the bench rate
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      idx_reg <= IDX_DONE;
      SERIAL_OUT <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b1;
      SHIFT_DONE_FLAG <= 1'b1;
    end else begin
      idx_reg <= idx_next;
      SERIAL_OUT <= (idx_next != IDX_DONE) ? result_next[IDX_DONE - 1'b1 - idx_next] : 1'b0;
      SERIAL_OUT_OE_N <= cs_s2;
      SHIFT_DONE_FLAG <= (idx_next == IDX_DONE);
    end
  end

  // ==================================================
  // Checks
  property p_done_low;
    @(posedge MCLK) disable iff (!RESET_N) (idx_reg != IDX_DONE) |-> !SHIFT_DONE_FLAG;
  endproperty
  a_done_low: assert property (p_done_low) else $error("shift done high mid word");

  property p_first_bit_cs;
    @(posedge MCLK) disable iff (!RESET_N)
      cs_fall |=> (idx_reg == '0) && (SERIAL_OUT == result_reg[asio_pkg::WORD_LEN-1]);
  endproperty
  a_first_bit_cs: assert property (p_first_bit_cs) else $error("first bit missing after select");

  property p_first_bit_eoc;
    @(posedge MCLK) disable iff (!RESET_N) (eoc_rise && !cs_s2 && !cs_fall) |=> idx_reg == '0;
  endproperty
  a_first_bit_eoc: assert property (p_first_bit_eoc) else $error("first bit missing at end of conversion");

  property p_step;
    @(posedge MCLK) disable iff (!RESET_N)
      (fall_ev && !cs_s2 && !cs_fall && !eoc_rise && idx_reg < IDX_DONE) |=> idx_reg == $past(idx_reg) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("result bit did not advance");

  property p_read_only;
    @(posedge MCLK) disable iff (!RESET_N) (word_ev && cw_s2) |=> $stable(CONFIG);
  endproperty
  a_read_only: assert property (p_read_only) else $error("read only frame changed config");

  property p_busy;
    @(posedge MCLK) disable iff (!RESET_N) (state_reg != asio_pkg::CV_IDLE) |-> !END_OF_CONFIG_WRITE_N;
  endproperty
  a_busy: assert property (p_busy) else $error("end of conversion high while busy");

  property p_start;
    @(posedge MCLK) disable iff (!RESET_N)
      (state_reg == asio_pkg::CV_ACQ && !cc_rise && !cs_fall) |=> state_reg == asio_pkg::CV_ACQ;
  endproperty
  a_start: assert property (p_start) else $error("acquisition left without conversion clock");

  property p_abort;
    @(posedge MCLK) disable iff (!RESET_N)
      (cs_fall && state_reg != asio_pkg::CV_IDLE) |=> state_reg == asio_pkg::CV_IDLE ##1 END_OF_CONFIG_WRITE_N;
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");

  property p_cfg_take;
    @(posedge MCLK) disable iff (!RESET_N) start_config_write_n |=> CONFIG == $past(cfg_hold_reg);
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("config not taken");
endmodule : asio_port
`default_nettype wire

/* tb/asio_host_model.sv */
`default_nettype none
// ==================================================
// Host side of the serial link
module asio_host_model (
  // Link pins
  output logic SCLK_IN,
  output logic CS_N,
  output logic SERIAL_IN,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE_N
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [12:0] rx_word;
  logic line;
  // Undriven line shows the inverse of the last bit, so a late enable is caught
  assign line = SERIAL_OUT_OE_N ? ~SERIAL_OUT : SERIAL_OUT;
  // Clock stands low between frames
  initial begin
    SCLK_IN = 1'b0;
    CS_N = 1'b1;
    SERIAL_IN = 1'b0;
  end
  // Select falls only with the clock low; wait covers the crossing
  task automatic sel();
    CS_N = 1'b0;
    #80;
  endtask : sel
  // Released data line toggles so a stale bit is never trusted
  task automatic desel();
    CS_N = 1'b1;
    SERIAL_IN = ~SERIAL_IN;
    #60;
  endtask : desel
  // Sample late: output lags the clock fall by the sync stages
  task automatic sample_bit(input int k);
    #50 rx_word[k] = line;
  endtask : sample_bit
  // Thirteen clocks, channel and mode bits first
  task automatic shift13(input logic [7:0] cfg);
    rx_word = 13'h0000;
    rx_word[12] = line;
    for (int i = 0; i < 13; i++) begin
      SERIAL_IN = (i < 8) ? cfg[7-i] : ~SERIAL_IN;
      #7.5 SCLK_IN = 1'b1;
      #15 SCLK_IN = 1'b0;
      if (i < 12) begin
        fork
          sample_bit(11 - i);
        join_none
      end
      #7.5;
    end
    #60;
  endtask : shift13
endmodule : asio_host_model
`default_nettype wire

/* tb/asio_port_bench.sv */
`default_nettype none
// ==================================================
// Bench for the serial port
module asio_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset_n, cfg_wr_n, config_write_n_clk, conversion_clock_run;
  logic sclk, cs_n, ser_in, ser_out, oe_n, done, eoc;
  logic [asio_pkg::WORD_LEN-1:0] sample_in, prev;
  asio_pkg::asio_cfg_t cfg_q, cfg_keep;
  logic [7:0] cfg_word;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  asio_port u_dut (.MCLK(mclk), .RESET_N(reset_n), .SCLK_IN(sclk), .CS_N(cs_n), .SERIAL_IN(ser_in),
    .CONFIG_WRITE_N(cfg_wr_n), .SERIAL_OUT(ser_out), .SERIAL_OUT_OE_N(oe_n), .SHIFT_DONE_FLAG(done),
    .CONVERSION_CLOCK(config_write_n_clk), .SAMPLE_IN(sample_in), .END_OF_CONFIG_WRITE_N(eoc), .CONFIG(cfg_q));
  asio_host_model host (.SCLK_IN(sclk), .CS_N(cs_n), .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out),
    .SERIAL_OUT_OE_N(oe_n));

  // ==================================================
  // Clocks and timeout
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Gated so a stopped conversion clock can be shown
  initial begin
    config_write_n_clk = 1'b0;
    forever #20 config_write_n_clk = conversion_clock_run & ~config_write_n_clk;
  end
  // Run is a few thousand cycles; ceiling is ten times that
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  // ==================================================
  // Helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expct);
    check_count++;
    if (seen !== expct) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, expct, seen);
    end
  endtask : check
  function automatic asio_pkg::asio_cfg_t exp_cfg(input logic [7:0] w);
    return '{input_selector: w[7:4], mode: w[3:0]};
  endfunction : exp_cfg
  // Bounded wait for the end of a cycle
  task automatic wait_eoc();
    for (int i = 0; i < 3000 && eoc !== 1'b1; i++) begin
      @(posedge mclk);
      #2;
    end
  endtask : wait_eoc
  // Config frame with select toggled
  task automatic cfg_frame(input logic [7:0] w);
    @(posedge mclk) #2 cfg_wr_n = 1'b0;
    host.sel();
    check("shift_done", {15'h0, done}, 16'h0000);
    check("oe_n", {15'h0, oe_n}, 16'h0000);
    host.shift13(w);
    host.desel();
  endtask : cfg_frame
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ==================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    cfg_wr_n = 1'b1;
    conversion_clock_run = 1'b1;
    sample_in = 13'h0000;
    prev = asio_pkg::RESULT_RST;
    void'($urandom(30686));
    repeat (4) @(posedge mclk);
    #2 reset_n = 1'b1;
    check("eoc", {15'h0, eoc}, 16'h0001);
    repeat (4) @(posedge mclk);
    for (int n = 0; n < 4; n++) begin
      cfg_word = (n == 0) ? 8'hFF : 8'($urandom);
      sample_in = (n == 0) ? 13'h1555 : 13'($urandom);
      cfg_frame(cfg_word);
      check("old_result", {3'h0, host.rx_word}, {3'h0, prev});
      check("config", {8'h0, cfg_q}, {8'h0, exp_cfg(cfg_word)});
      check("eoc", {15'h0, eoc}, 16'h0000);
      if (n == 1) begin
        conversion_clock_run = 1'b0;
        #3000;
        check("eoc", {15'h0, eoc}, 16'h0000);
        conversion_clock_run = 1'b1;
      end
      wait_eoc();
      check("eoc", {15'h0, eoc}, 16'h0001);
      // Read-only frame must leave setup and converter alone
      cfg_keep = cfg_q;
      @(posedge mclk) #2 cfg_wr_n = 1'b1;
      host.sel();
      host.shift13(~cfg_word);
      check("result", {3'h0, host.rx_word}, {3'h0, sample_in});
      check("shift_done", {15'h0, done}, 16'h0001);
      host.desel();
      check("oe_n", {15'h0, oe_n}, 16'h0001);
      check("config", {8'h0, cfg_q}, {8'h0, cfg_keep});
      check("eoc", {15'h0, eoc}, 16'h0001);
      prev = sample_in;
    end
    // Select held low across the conversion
    sample_in = 13'($urandom);
    @(posedge mclk) #2 cfg_wr_n = 1'b0;
    host.sel();
    host.shift13(8'h3C);
    check("old_result", {3'h0, host.rx_word}, {3'h0, prev});
    check("config", {8'h0, cfg_q}, {8'h0, exp_cfg(8'h3C)});
    wait_eoc();
    @(posedge mclk) #2 cfg_wr_n = 1'b1;
    host.shift13(8'h00);
    check("result", {3'h0, host.rx_word}, {3'h0, sample_in});
    host.desel();
    prev = sample_in;
    // Select falling mid-conversion aborts it
    cfg_frame(8'hA5);
    repeat (20) @(posedge config_write_n_clk);
    @(posedge mclk) #2 cfg_wr_n = 1'b1;
    check("eoc", {15'h0, eoc}, 16'h0000);
    host.sel();
    check("eoc", {15'h0, eoc}, 16'h0001);
    host.shift13(8'h00);
    host.desel();
    check("eoc", {15'h0, eoc}, 16'h0001);
    check("config", {8'h0, cfg_q}, {8'h0, exp_cfg(8'hA5)});
    complete_run();
  end
endmodule : asio_port_bench
`default_nettype wire
